/* aics_sequencer.sv */
// Idle and calibration mode sequencer with APB registers and interrupt
//
// Functional notes
// R1 - Codes 0000 continuous (reset), 0001 single, 0010 standby, 0011 power-down decoded
// R2 - Mode 0100 holds filter and modulator reset, modulator clock keeps running
// R3 - Mode 0101 shorts input, stores offset coefficient for selected channel
// R4 - Ready flag high when any calibration starts, low when it finishes
// R5 - Mode returns to idle automatically after any calibration
// R6 - Internal zero, system zero, system full calibrations last one settling period
// R7 - Mode 0110 applies internal full-scale, stores gain coefficient for channel
// R8 - Internal full-scale calibration at gain above one takes four settling periods
// R9 - Host never requests internal full-scale calibration at gain one
// R10 - Host selects mid or low power before internal full-scale calibration
// R11 - Gain coefficient from mid or low power stays applied in full power
// R12 - Host runs internal full-scale before internal zero-scale calibration
// R13 - Host writes 0x800000 to offset register before internal full-scale
// R14 - Host enables exactly one channel during any calibration
// R15 - Mode 0111 measures external zero input, stores channel offset coefficient
// R16 - Mode 1000 measures external full-scale input, stores channel gain coefficient
// R17 - Host repeats full-scale and system zero calibrations after gain change
// R18 - Host never writes reserved mode codes 1001 to 1111
`timescale 1ns/1ps
module aics_sequencer #(
    parameter int CHANNELS      = 16,
    parameter int SETTLE_CYCLES = aics_pkg::SETTLE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        clkEn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [23:0] measResult,
    output logic             convReady,
    output logic             filterReset,
    output logic             modClkEn,
    output logic             inputShort,
    output logic             fullScaleApply,
    output logic             modeContinuous,
    output logic             modeSingle,
    output logic             modeStandby,
    output logic             modePowerDown,
    output logic             irq
);
    localparam int CW = $clog2(CHANNELS);
    localparam int SW = $clog2(SETTLE_CYCLES * aics_pkg::SETTLE_PERIODS_IFS + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Reset synchroniser
    logic rstMeta_r;
    logic rstSync_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end
    wire logic rstnInt = rstSync_r;

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [3:0]    mode_r;
    logic [1:0]    power_r;
    logic [CW-1:0] chSel_r;
    logic [1:0]    irqStat_r;
    logic [1:0]    irqEn_r;
    logic [23:0]   offsetMem [CHANNELS];
    logic [23:0]   gainMem   [CHANNELS];
    aics_pkg::aics_state_t state_r;
    aics_pkg::aics_state_t state_nxt;
    logic [SW-1:0] cnt_r;
    logic          ready_r;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire logic access   = psel && penable;
    wire logic wrEn     = access && pwrite && clkEn;
    wire logic hitCtrl  = paddr == aics_pkg::ADDR_CTRL;
    wire logic hitStat  = paddr == aics_pkg::ADDR_STATUS;
    wire logic hitIrqS  = paddr == aics_pkg::ADDR_IRQSTAT;
    wire logic hitIrqC  = paddr == aics_pkg::ADDR_IRQCLR;
    wire logic hitIrqE  = paddr == aics_pkg::ADDR_IRQEN;
    wire logic hitOff   = paddr == aics_pkg::ADDR_OFFSET;
    wire logic hitGain  = paddr == aics_pkg::ADDR_GAIN;
    wire logic hitChSel = paddr == aics_pkg::ADDR_CHSEL;
    wire logic hitAny   = hitCtrl || hitStat || hitIrqS || hitIrqC || hitIrqE
                          || hitOff || hitGain || hitChSel;

    assign pready  = 1'b1;
    assign pslverr = access && !hitAny;

    function automatic logic isCal(input logic [3:0] m);
        isCal = (m >= aics_pkg::MODE_IZS) && (m <= aics_pkg::MODE_SFS);
    endfunction : isCal

    ////////////////////////////////////////////////////////////////////////////
    // Calibration sequencer
    wire logic calReq    = isCal(mode_r);
    wire logic isIfs     = mode_r == aics_pkg::MODE_IFS;
    wire logic storeOff  = (mode_r == aics_pkg::MODE_IZS) || (mode_r == aics_pkg::MODE_SZS);
    wire logic [SW-1:0] calLen = isIfs                                   // R8
        ? SW'(SETTLE_CYCLES * aics_pkg::SETTLE_PERIODS_IFS)
        : SW'(SETTLE_CYCLES * aics_pkg::SETTLE_PERIODS_SHORT);           // R6
    wire logic calStart  = state_r == aics_pkg::ST_START;
    wire logic calDone   = state_r == aics_pkg::ST_STORE;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            aics_pkg::ST_IDLE: begin
                if (calReq) begin
                    state_nxt = aics_pkg::ST_START;
                end
            end
            aics_pkg::ST_START: begin
                state_nxt = aics_pkg::ST_RUN;
            end
            aics_pkg::ST_RUN: begin
                if (cnt_r == SW'(1)) begin
                    state_nxt = aics_pkg::ST_STORE;
                end
            end
            aics_pkg::ST_STORE: begin
                state_nxt = aics_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = aics_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            state_r <= aics_pkg::ST_IDLE;
            cnt_r   <= '0;
            ready_r <= 1'b0;
        end else if (clkEn) begin
            state_r <= state_nxt;
            if (calStart) begin
                cnt_r   <= calLen;
                ready_r <= 1'b1;                                       // R4
            end else if (state_r == aics_pkg::ST_RUN) begin
                cnt_r <= cnt_r - SW'(1);
            end
            if (calDone) begin
                ready_r <= 1'b0;                                       // R4
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers; CTRL and CHSEL writes land only in ST_IDLE, calibration end forces idle
    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            mode_r  <= aics_pkg::MODE_CONT;                            // R1
            power_r <= aics_pkg::PWR_LOW;
            chSel_r <= '0;
            irqEn_r <= '0;
        end else if (clkEn) begin
            if (wrEn && hitCtrl && state_r == aics_pkg::ST_IDLE) begin
                mode_r  <= pwdata[aics_pkg::CTRL_MODE_LSB +: 4];
                power_r <= pwdata[aics_pkg::CTRL_POWER_LSB +: 2];
            end
            if (calDone) begin
                mode_r <= aics_pkg::MODE_IDLE;                         // R5
            end
            if (wrEn && hitChSel && state_r == aics_pkg::ST_IDLE) begin
                chSel_r <= pwdata[CW-1:0];
            end
            if (wrEn && hitIrqE) begin
                irqEn_r <= pwdata[1:0];
            end
        end
    end

    // Coefficient storage; gain entry holds regardless of later power mode (R11)
    // Entries start at their defaults so a read before any calibration is defined
    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            for (int i = 0; i < CHANNELS; i++) begin
                offsetMem[i] <= aics_pkg::OFFSET_RESET;
                gainMem[i]   <= aics_pkg::GAIN_RESET;
            end
        end else if (clkEn) begin
            if (calDone && storeOff) begin
                offsetMem[chSel_r] <= measResult;                      // R3 R15
            end else if (wrEn && hitOff) begin
                offsetMem[chSel_r] <= pwdata[23:0];
            end
            if (calDone && !storeOff) begin
                gainMem[chSel_r] <= measResult;                        // R7 R16 R11
            end else if (wrEn && hitGain) begin
                gainMem[chSel_r] <= pwdata[23:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over clear
    wire logic [1:0] irqSet = {calDone, calStart};
    wire logic [1:0] irqClr = (wrEn && hitIrqC) ? pwdata[1:0] : 2'h0;
    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            irqStat_r <= '0;
        end else if (clkEn) begin
            irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
        end
    end
    assign irq = |(irqStat_r & irqEn_r);

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    wire logic [31:0] rdMux =
        hitCtrl  ? {26'h0, power_r, mode_r} :
        hitStat  ? {24'h0, 3'h0, ready_r, state_r} :
        hitIrqS  ? {30'h0, irqStat_r} :
        hitIrqE  ? {30'h0, irqEn_r} :
        hitOff   ? {8'h0, offsetMem[chSel_r]} :
        hitGain  ? {8'h0, gainMem[chSel_r]} :
        hitChSel ? 32'(chSel_r) : 32'h0;
    assign prdata = (access && !pwrite) ? rdMux : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode to analog controls
    assign convReady      = ready_r;
    assign filterReset    = (mode_r == aics_pkg::MODE_IDLE) || !rstnInt;  // R2
    assign modClkEn       = !(mode_r == aics_pkg::MODE_STANDBY
                              || mode_r == aics_pkg::MODE_PWRDN);          // R2
    assign inputShort     = mode_r == aics_pkg::MODE_IZS;                  // R3
    assign fullScaleApply = isIfs;                                         // R7
    assign modeContinuous = mode_r == aics_pkg::MODE_CONT;                 // R1
    assign modeSingle     = mode_r == aics_pkg::MODE_SINGLE;               // R1
    assign modeStandby    = mode_r == aics_pkg::MODE_STANDBY;              // R1
    assign modePowerDown  = mode_r == aics_pkg::MODE_PWRDN;                // R1

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_ready_on_start;
        @(posedge clk) disable iff (!rstnInt)
        (clkEn && calStart) |=> convReady;
    endproperty
    a_ready_on_start: assert property (p_ready_on_start) else $error("ready not raised"); // R4

    property p_ready_off_done;
        @(posedge clk) disable iff (!rstnInt)
        (clkEn && calDone) |=> !convReady;
    endproperty
    a_ready_off_done: assert property (p_ready_off_done) else $error("ready not cleared"); // R4

    property p_idle_after;
        @(posedge clk) disable iff (!rstnInt)
        (clkEn && calDone) |=> mode_r == aics_pkg::MODE_IDLE;
    endproperty
    a_idle_after: assert property (p_idle_after) else $error("no idle after cal"); // R5

    property p_filter_idle;
        @(posedge clk) disable iff (!rstnInt)
        (mode_r == aics_pkg::MODE_IDLE) |-> (filterReset && modClkEn);
    endproperty
    a_filter_idle: assert property (p_filter_idle) else $error("idle controls wrong"); // R2

    property p_short;
        @(posedge clk) disable iff (!rstnInt)
        inputShort |-> mode_r == aics_pkg::MODE_IZS;
    endproperty
    a_short: assert property (p_short) else $error("short in wrong mode"); // R3

    property p_ifs_len;
        @(posedge clk) disable iff (!rstnInt)
        (clkEn && calStart && isIfs) |=> cnt_r == SW'(SETTLE_CYCLES * 4);
    endproperty
    a_ifs_len: assert property (p_ifs_len) else $error("ifs length wrong"); // R8

    property p_short_len;
        @(posedge clk) disable iff (!rstnInt)
        (clkEn && calStart && !isIfs) |=> cnt_r == SW'(SETTLE_CYCLES);
    endproperty
    a_short_len: assert property (p_short_len) else $error("cal length wrong"); // R6

    property p_cont_reset;
        @(posedge clk) $rose(rstnInt) |-> modeContinuous;
    endproperty
    a_cont_reset: assert property (p_cont_reset) else $error("reset mode wrong"); // R1

    property p_ready_reset;
        @(posedge clk) $rose(rstnInt) |-> !convReady;
    endproperty
    a_ready_reset: assert property (p_ready_reset) else $error("ready high after reset"); // R4

    property p_ready_run;
        @(posedge clk) disable iff (!rstnInt)
        (state_r == aics_pkg::ST_RUN) |-> convReady;
    endproperty
    a_ready_run: assert property (p_ready_run) else $error("ready low while running"); // R4

    property p_ready_idle;
        @(posedge clk) disable iff (!rstnInt)
        (state_r == aics_pkg::ST_IDLE) |-> !convReady;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready high while idle"); // R4

    property p_ready_rise;
        @(posedge clk) disable iff (!rstnInt)
        $rose(convReady) |-> (state_r == aics_pkg::ST_RUN) && calReq;
    endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("ready rose outside start"); // R4

    property p_ready_fall;
        @(posedge clk) disable iff (!rstnInt)
        $fell(convReady) |-> (mode_r == aics_pkg::MODE_IDLE);
    endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("ready fell without idle"); // R5

    property p_cal_code;
        @(posedge clk) disable iff (!rstnInt)
        (state_r != aics_pkg::ST_IDLE) |-> isCal(mode_r);
    endproperty
    a_cal_code: assert property (p_cal_code) else $error("mode left cal too early"); // R5

    property p_run_bounded;
        @(posedge clk) disable iff (!rstnInt)
        (state_r == aics_pkg::ST_RUN) |-> (cnt_r != '0) && (cnt_r <= calLen);
    endproperty
    a_run_bounded: assert property (p_run_bounded) else $error("run count out of range"); // R6 R8

    property p_offset_store;
        @(posedge clk) disable iff (!rstnInt)
        (clkEn && calDone && storeOff) |=> offsetMem[chSel_r] == $past(measResult);
    endproperty
    a_offset_store: assert property (p_offset_store) else $error("offset not stored"); // R3 R15

    property p_gain_store;
        @(posedge clk) disable iff (!rstnInt)
        (clkEn && calDone && !storeOff) |=> gainMem[chSel_r] == $past(measResult);
    endproperty
    a_gain_store: assert property (p_gain_store) else $error("gain not stored"); // R7 R16
endmodule : aics_sequencer

/* aics_pkg.sv */
// Package: mode codes, register map and timing counts for the calibration sequencer
package aics_pkg;
    localparam logic [3:0] MODE_CONT    = 4'h0;
    localparam logic [3:0] MODE_SINGLE  = 4'h1;
    localparam logic [3:0] MODE_STANDBY = 4'h2;
    localparam logic [3:0] MODE_PWRDN   = 4'h3;
    localparam logic [3:0] MODE_IDLE    = 4'h4;
    localparam logic [3:0] MODE_IZS     = 4'h5;
    localparam logic [3:0] MODE_IFS     = 4'h6;
    localparam logic [3:0] MODE_SZS     = 4'h7;
    localparam logic [3:0] MODE_SFS     = 4'h8;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_IRQSTAT = 8'h08;
    localparam logic [7:0] ADDR_IRQCLR  = 8'h0C;
    localparam logic [7:0] ADDR_IRQEN   = 8'h10;
    localparam logic [7:0] ADDR_OFFSET  = 8'h14;
    localparam logic [7:0] ADDR_GAIN    = 8'h18;
    localparam logic [7:0] ADDR_CHSEL   = 8'h1C;

    // CTRL fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_POWER_LSB = 4;
    localparam logic [1:0] PWR_LOW  = 2'h0;
    localparam logic [1:0] PWR_MID  = 2'h1;
    localparam logic [1:0] PWR_FULL = 2'h2;

    // Interrupt bits
    localparam int IRQ_START = 0;
    localparam int IRQ_DONE  = 1;

    localparam logic [23:0] OFFSET_RESET = 24'h800000;
    localparam logic [23:0] GAIN_RESET   = 24'h500000;

    localparam int SETTLE_PERIODS_SHORT = 1;
    localparam int SETTLE_PERIODS_IFS   = 4;
    localparam int SETTLE_CYCLES        = 64;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_START  = 4'b0010,
        ST_RUN    = 4'b0100,
        ST_STORE  = 4'b1000
    } aics_state_t;
endpackage : aics_pkg

/* aics_host_model.sv */
// Host-side APB master model driving the calibration sequencer registers
`timescale 1ns/1ps
module aics_host_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic        timedOut;
    logic [31:0] rdData;
    logic        rdErr;
    initial begin
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 8'h00;
        pwdata   = 32'h00000000;
        timedOut = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Idle bus carries the inverse of the last address and write data so stale values never match
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) timedOut = 1'b1;
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : xfer
endmodule : aics_host_model

/* adc_idle_and_calibration_sequencer_bench.sv */
// Self-checking bench for the idle and calibration sequencer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin failCount++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, (exp), (got)); end end
module adc_idle_and_calibration_sequencer_bench;
    localparam int SC = 4;
    typedef struct {
        logic [3:0]  mode;
        int          periods;
        logic [7:0]  coefAddr;
        logic        shortExp;
        logic        fsExp;
        logic [23:0] meas;
    } aics_row_t;
    logic clk, rstn, clkEn, psel, penable, pwrite, pready, pslverr, convReady, filterReset;
    logic modClkEn, inputShort, fullScaleApply, irq, mCont, mSingle, mStby, mPdn;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [23:0] measResult;
    int          failCount = 0;
    int          testsRun = 0;
    aics_row_t   rows[4];
    aics_sequencer #(.SETTLE_CYCLES(SC)) DUT (.clk(clk), .rstn(rstn), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .measResult(measResult),
        .convReady(convReady), .filterReset(filterReset), .modClkEn(modClkEn),
        .inputShort(inputShort), .fullScaleApply(fullScaleApply), .modeContinuous(mCont),
        .modeSingle(mSingle), .modeStandby(mStby), .modePowerDown(mPdn), .irq(irq));
    aics_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrapUp();
        if (host.timedOut) failCount++;
        if (failCount == 0 && testsRun > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrapUp
    // Ready flag is counted while high; allow a few cycles of start and store overhead
    task automatic runCal(input aics_row_t r);
        int n;
        int hi;
        logic sh;
        logic fs;
        @(posedge clk);
        measResult <= r.meas;
        host.xfer(1'b1, aics_pkg::ADDR_CTRL, {26'h0, aics_pkg::PWR_MID, r.mode});
        n = 0;
        while (convReady !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) begin
            failCount++;
            wrapUp();
        end
        sh = inputShort;
        fs = fullScaleApply;
        hi = 0;
        while (convReady === 1'b1 && hi < 200) begin
            @(posedge clk);
            hi++;
        end
        if (hi >= 200) begin
            failCount++;
            wrapUp();
        end
        `CHK("inputShort", r.shortExp, sh)
        `CHK("fullScaleApply", r.fsExp, fs)
        `CHK("readyTime", 1'b1, hi >= r.periods * SC && hi <= r.periods * SC + 3)
        host.xfer(1'b0, aics_pkg::ADDR_CTRL, 32'h0);
        `CHK("modeAfterCal", aics_pkg::MODE_IDLE, host.rdData[3:0])
        `CHK("filterReset", 1'b1, filterReset)
        `CHK("modClkEn", 1'b1, modClkEn)
        host.xfer(1'b0, r.coefAddr, 32'h0);
        `CHK("coefficient", r.meas, host.rdData[23:0])
    endtask : runCal
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failCount++;
        wrapUp();
    end
    initial begin
        // Internal full-scale runs first, then internal zero-scale
        // Channel under internal full-scale is taken to sit above unity gain
        rows[0] = '{aics_pkg::MODE_IFS, 4, aics_pkg::ADDR_GAIN, 1'b0, 1'b1, 24'h5A5A5A};
        rows[1] = '{aics_pkg::MODE_IZS, 1, aics_pkg::ADDR_OFFSET, 1'b1, 1'b0, 24'h7F0001};
        rows[2] = '{aics_pkg::MODE_SZS, 1, aics_pkg::ADDR_OFFSET, 1'b0, 1'b0, 24'h812345};
        rows[3] = '{aics_pkg::MODE_SFS, 1, aics_pkg::ADDR_GAIN, 1'b0, 1'b0, 24'h3C3C3C};
        rstn = 1'b0;
        clkEn = 1'b1;
        measResult = 24'h000000;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        host.xfer(1'b0, aics_pkg::ADDR_CTRL, 32'h0);
        `CHK("resetMode", aics_pkg::MODE_CONT, host.rdData[3:0])
        host.xfer(1'b0, aics_pkg::ADDR_OFFSET, 32'h0);
        `CHK("offsetReset", aics_pkg::OFFSET_RESET, host.rdData[23:0])
        // Codes written stay at 1000 or below
        for (int m = 0; m < 4; m++) begin
            host.xfer(1'b1, aics_pkg::ADDR_CTRL, {26'h0, aics_pkg::PWR_MID, 4'(m)});
            repeat (2) @(posedge clk);
            `CHK("modeDecode", 4'h8 >> m, {mCont, mSingle, mStby, mPdn})
            `CHK("modClkRun", m < 2, modClkEn)
            `CHK("filterRun", 1'b0, filterReset)
        end
        host.xfer(1'b1, aics_pkg::ADDR_IRQEN, 32'h0);
        host.xfer(1'b1, aics_pkg::ADDR_CHSEL, 32'h1);
        host.xfer(1'b1, aics_pkg::ADDR_OFFSET, 32'h00800000);
        for (int i = 0; i < 4; i++) begin
            runCal(rows[i]);
            if (i == 0) begin
                host.xfer(1'b1, aics_pkg::ADDR_CTRL, {26'h0, aics_pkg::PWR_FULL, 4'h4});
                host.xfer(1'b0, aics_pkg::ADDR_GAIN, 32'h0);
                `CHK("gainFullPower", rows[0].meas, host.rdData[23:0])
            end
        end
        `CHK("irqMasked", 1'b0, irq)
        host.xfer(1'b1, aics_pkg::ADDR_IRQEN, 32'h3);
        @(posedge clk);
        `CHK("irqRaised", 1'b1, irq)
        host.xfer(1'b0, aics_pkg::ADDR_IRQSTAT, 32'h0);
        `CHK("irqStatus", 2'h3, host.rdData[1:0])
        host.xfer(1'b1, aics_pkg::ADDR_IRQCLR, 32'h3);
        @(posedge clk);
        `CHK("irqCleared", 1'b0, irq)
        host.xfer(1'b0, 8'h20, 32'h0);
        `CHK("unmappedErr", 1'b1, host.rdErr)
        wrapUp();
    end
endmodule : adc_idle_and_calibration_sequencer_bench
